// File: scp_port_decode.sv
`timescale 1ns/1ps

module scp_port_decode (
  input  wire logic       sys_clk_in,          // System clock, 25 MHz.
  input  wire logic       rst_n_in,            // Synchronous reset, active low.
  input  wire logic [7:0] low_port_address_in, // Processor address bits 7..0.
  input  wire logic       io_rd_n_in,          // Processor I/O read strobe, active low.
  input  wire logic       io_wr_n_in,          // Processor I/O write strobe, active low.
  input  wire logic [7:0] cpu_data_in,         // Processor data bus, input half.
  output logic      [7:0] cpu_data_out,        // Processor data bus, output half.
  output logic            cpu_data_oe_out,     // Data bus output enable.
  output logic      [7:0] select_n_out,        // Eight select strobes, active low.
  input  wire logic       xtal_ref_in,         // Crystal reference, 5.0688 MHz.
  output logic            tx_clock_16x_out,    // Transmit clock to serial core.
  output logic            rx_clock_16x_out,    // Receive clock to serial core.
  input  wire logic [7:0] config_switches_in,  // Switch levels, open reads one.
  input  wire logic       cts_in,              // Clear to send, on high.
  input  wire logic       dsr_in,              // Data set ready, on high.
  input  wire logic       dcd_in,              // Carrier detect, on high.
  input  wire logic       ri_in,               // Ring indicator, on high.
  input  wire logic       serial_rx_in,        // Receiver input line level.
  output logic            rts_out,             // Request to send.
  output logic            dtr_out,             // Data terminal ready.
  output logic            core_reset_n_out,    // Serial core reset pulse, active low.
  output logic            even_parity_out,     // Core format: even parity.
  output logic      [1:0] word_len_sel_out,    // Core format: word length select.
  output logic            two_stop_out,        // Core format: two stop bits.
  output logic            parity_inhibit_out,  // Core format: no parity.
  output logic            break_n_out,         // Low disables transmit data.
  output logic      [7:0] tx_data_out,         // Character for the core.
  output logic            tx_load_out,         // Load pulse for tx_data_out.
  output logic            rx_read_out,         // Pulse clearing the received flag.
  input  wire logic [7:0] rx_data_in,          // Core receive holding register.
  input  wire logic       rx_ready_in,         // Core: data received.
  input  wire logic       thr_empty_in,        // Core: holding register empty.
  input  wire logic       overrun_in,          // Core: overrun error.
  input  wire logic       framing_err_in,      // Core: framing error.
  input  wire logic       parity_err_in        // Core: parity error.
);

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [scp_pkg::SY_WIDTH-1:0] sync1;
    logic [scp_pkg::SY_WIDTH-1:0] sync2;
    logic [scp_pkg::SY_WIDTH-1:0] sync3;
    logic [scp_pkg::SY_WIDTH-1:0] stable;
    logic                         rd_prev_n;
    logic                         wr_prev_n;
    logic                         xtal_prev;
    logic                         ref_tick;
    logic [7:0]                   select_n;
    logic [7:0]                   rd_data;
    logic                         rd_oe;
    logic [7:0]                   baud_code;
    logic [7:0]                   ctl_latch;
    logic [7:0]                   tx_data;
    logic                         tx_load;
    logic                         rx_read;
    logic                         core_reset_n;
  } scp_top_s;

  scp_top_s                     st_reg;
  scp_top_s                     st_next;
  logic [scp_pkg::SY_WIDTH-1:0] pins;
  logic [7:0]                   addr;
  logic [7:0]                   wdata;
  logic                         rd_act;
  logic                         wr_act;
  logic                         hit;
  logic [1:0]                   port;
  logic                         wr_start;
  logic                         rd_start;

  assign pins = {xtal_ref_in, serial_rx_in, ri_in, dcd_in, dsr_in, cts_in,
                 io_wr_n_in, io_rd_n_in, config_switches_in, cpu_data_in,
                 low_port_address_in};

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    st_next       = st_reg;
    // Pins pass three flops; a bit changes once the last two agree.
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int i = 0; i < scp_pkg::SY_WIDTH; i++) begin
      if (st_reg.sync2[i] == st_reg.sync3[i]) begin
        st_next.stable[i] = st_reg.sync3[i];
      end
    end
    addr     = st_reg.stable[scp_pkg::SY_ADDR +: 8];
    wdata    = st_reg.stable[scp_pkg::SY_DATA +: 8];
    rd_act   = ~st_reg.stable[scp_pkg::SY_RD_N];
    wr_act   = ~st_reg.stable[scp_pkg::SY_WR_N];
    hit      = (addr[7:2] == scp_pkg::PORT_BLOCK);
    port     = addr[1:0];
    wr_start = wr_act && st_reg.wr_prev_n;
    rd_start = rd_act && st_reg.rd_prev_n;
    st_next.rd_prev_n = ~rd_act;
    st_next.wr_prev_n = ~wr_act;

    // Crystal rising edge becomes a one-cycle tick for both dividers.
    st_next.xtal_prev = st_reg.stable[scp_pkg::SY_XTAL];
    st_next.ref_tick  = st_reg.stable[scp_pkg::SY_XTAL] && !st_reg.xtal_prev;

    // Strobes follow address match and I/O strobe, nothing else.
    st_next.select_n = 8'hff;
    if (hit && wr_act) begin
      st_next.select_n[scp_pkg::STB_WR_BASE + 32'(port)] = 1'b0;
    end
    if (hit && rd_act) begin
      st_next.select_n[scp_pkg::STB_RD_BASE + 32'(port)] = 1'b0;
    end

    st_next.tx_load      = 1'b0;
    st_next.rx_read      = 1'b0;
    st_next.core_reset_n = 1'b1;

    // ****************************************************
    // Port writes, taken once as the write strobe starts
    // ****************************************************
    if (hit && wr_start) begin
      unique case (addr)
        scp_pkg::PORT_RESET_MODEM: begin
          st_next.core_reset_n = 1'b0;
        end
        scp_pkg::PORT_BAUD_SWITCH: begin
          st_next.baud_code = wdata;
        end
        scp_pkg::PORT_CTRL_STATUS: begin
          st_next.ctl_latch = wdata;
        end
        scp_pkg::PORT_DATA: begin
          st_next.tx_data = wdata;
          st_next.tx_load = 1'b1;
        end
      endcase
    end

    // ****************************************************
    // Port reads, bus driven only while the read strobe lasts
    // ****************************************************
    st_next.rd_oe = hit && rd_act;
    if (!(hit && rd_act)) begin
      st_next.rd_data = 8'h00;
    end else begin
      unique case (addr)
        scp_pkg::PORT_RESET_MODEM: begin
          st_next.rd_data                      = 8'h00;
          st_next.rd_data[scp_pkg::MST_CTS]    = st_reg.stable[scp_pkg::SY_CTS];
          st_next.rd_data[scp_pkg::MST_DSR]    = st_reg.stable[scp_pkg::SY_DSR];
          st_next.rd_data[scp_pkg::MST_DCD]    = st_reg.stable[scp_pkg::SY_DCD];
          st_next.rd_data[scp_pkg::MST_RI]     = st_reg.stable[scp_pkg::SY_RI];
          st_next.rd_data[scp_pkg::MST_SER_IN] = st_reg.stable[scp_pkg::SY_SERIN];
        end
        scp_pkg::PORT_BAUD_SWITCH: begin
          st_next.rd_data = st_reg.stable[scp_pkg::SY_SW +: 8];
        end
        scp_pkg::PORT_CTRL_STATUS: begin
          st_next.rd_data = {rx_ready_in, thr_empty_in, overrun_in,
                             framing_err_in, parity_err_in, 3'h0};
        end
        scp_pkg::PORT_DATA: begin
          // Data is frozen at the start of the read so the clear cannot disturb it.
          if (rd_start) begin
            st_next.rd_data = rx_data_in;
            st_next.rx_read = 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_reg              <= '0;
      st_reg.sync1        <= '1;
      st_reg.sync2        <= '1;
      st_reg.sync3        <= '1;
      st_reg.stable       <= '1;
      st_reg.rd_prev_n    <= 1'b1;
      st_reg.wr_prev_n    <= 1'b1;
      st_reg.xtal_prev    <= 1'b1;
      st_reg.select_n     <= 8'hff;
      st_reg.baud_code    <= scp_pkg::BAUD_RESET_VAL;
      st_reg.ctl_latch    <= scp_pkg::CTL_RESET_VAL;
      st_reg.core_reset_n <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************
  // Divider channels
  // ****************************************************
  scp_baud_channel u_tx_chan (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .ref_tick_in  (st_reg.ref_tick),
    .rate_code_in (st_reg.baud_code[7:4]),
    .clk16_out    (tx_clock_16x_out)
  );

  scp_baud_channel u_rx_chan (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .ref_tick_in  (st_reg.ref_tick),
    .rate_code_in (st_reg.baud_code[3:0]),
    .clk16_out    (rx_clock_16x_out)
  );

  assign cpu_data_out       = st_reg.rd_data;
  assign cpu_data_oe_out    = st_reg.rd_oe;
  assign select_n_out       = st_reg.select_n;
  assign rts_out            = st_reg.ctl_latch[scp_pkg::CTL_RTS];
  assign dtr_out            = st_reg.ctl_latch[scp_pkg::CTL_DTR];
  assign break_n_out        = st_reg.ctl_latch[scp_pkg::CTL_BREAK_N];
  assign even_parity_out    = st_reg.ctl_latch[scp_pkg::CTL_EVEN_PAR];
  assign word_len_sel_out   = {st_reg.ctl_latch[scp_pkg::CTL_WLEN_HI], st_reg.ctl_latch[scp_pkg::CTL_WLEN_LO]};
  assign two_stop_out       = st_reg.ctl_latch[scp_pkg::CTL_TWO_STOP];
  assign parity_inhibit_out = st_reg.ctl_latch[scp_pkg::CTL_PAR_INH];
  assign core_reset_n_out   = st_reg.core_reset_n;
  assign tx_data_out        = st_reg.tx_data;
  assign tx_load_out        = st_reg.tx_load;
  assign rx_read_out        = st_reg.rx_read;

endmodule

// File: scp_pkg.sv
package scp_pkg;

  // ****************************************************
  // Clock rates
  // ****************************************************
  localparam int unsigned SYS_CLK_HZ    = 25000000;
  localparam int unsigned XTAL_REF_HZ   = 5068800;
  localparam int unsigned CLK16_FACTOR  = 16;

  // ****************************************************
  // Port addresses on the low eight address bits
  // ****************************************************
  localparam logic [7:0] PORT_RESET_MODEM = 8'he8;
  localparam logic [7:0] PORT_BAUD_SWITCH = 8'he9;
  localparam logic [7:0] PORT_CTRL_STATUS = 8'hea;
  localparam logic [7:0] PORT_DATA        = 8'heb;
  localparam logic [5:0] PORT_BLOCK       = 6'h3a;

  // ****************************************************
  // Strobe vector positions: writes low, reads high
  // ****************************************************
  localparam int unsigned STB_WR_BASE = 0;
  localparam int unsigned STB_RD_BASE = 4;

  // ****************************************************
  // Control and handshake latch fields
  // ****************************************************
  localparam int unsigned CTL_EVEN_PAR  = 7;
  localparam int unsigned CTL_WLEN_HI   = 6;
  localparam int unsigned CTL_WLEN_LO   = 5;
  localparam int unsigned CTL_TWO_STOP  = 4;
  localparam int unsigned CTL_PAR_INH   = 3;
  localparam int unsigned CTL_BREAK_N   = 2;
  localparam int unsigned CTL_RTS       = 1;
  localparam int unsigned CTL_DTR       = 0;
  localparam logic [7:0]  CTL_RESET_VAL = 8'h00;

  // ****************************************************
  // Modem status fields and baud divider reset value
  // ****************************************************
  localparam int unsigned MST_CTS      = 7;
  localparam int unsigned MST_DSR      = 6;
  localparam int unsigned MST_DCD      = 5;
  localparam int unsigned MST_RI       = 4;
  localparam int unsigned MST_SER_IN   = 1;
  localparam logic [7:0]  BAUD_RESET_VAL = 8'h22;

  // ****************************************************
  // Synchroniser vector layout
  // ****************************************************
  localparam int unsigned SY_ADDR  = 0;
  localparam int unsigned SY_DATA  = 8;
  localparam int unsigned SY_SW    = 16;
  localparam int unsigned SY_RD_N  = 24;
  localparam int unsigned SY_WR_N  = 25;
  localparam int unsigned SY_CTS   = 26;
  localparam int unsigned SY_DSR   = 27;
  localparam int unsigned SY_DCD   = 28;
  localparam int unsigned SY_RI    = 29;
  localparam int unsigned SY_SERIN = 30;
  localparam int unsigned SY_XTAL  = 31;
  localparam int unsigned SY_WIDTH = 32;

  // ****************************************************
  // Crystal edges per 16x clock period for each rate code.
  // ****************************************************
  function automatic logic [12:0] divisor(input logic [3:0] code);
    logic [12:0] d;
    d = 13'h0010;
    case (code)
      4'h0: d = 13'h18c0;
      4'h1: d = 13'h1080;
      4'h2: d = 13'h0b40;
      4'h3: d = 13'h0933;
      4'h4: d = 13'h0840;
      4'h5: d = 13'h0420;
      4'h6: d = 13'h0210;
      4'h7: d = 13'h0108;
      4'h8: d = 13'h00b0;
      4'h9: d = 13'h009e;
      4'ha: d = 13'h0084;
      4'hb: d = 13'h0058;
      4'hc: d = 13'h0042;
      4'hd: d = 13'h002c;
      4'he: d = 13'h0021;
      4'hf: d = 13'h0010;
    endcase
    return d;
  endfunction

endpackage

// File: scp_baud_channel.sv
`timescale 1ns/1ps

module scp_baud_channel (
  input  wire logic       sys_clk_in,     // System clock.
  input  wire logic       rst_n_in,       // Synchronous reset, active low.
  input  wire logic       ref_tick_in,    // One pulse per crystal rising edge.
  input  wire logic [3:0] rate_code_in,   // Rate code for this direction.
  output logic            clk16_out       // Clock at sixteen times the bit rate.
);

  typedef struct packed {
    logic [12:0] count;
    logic        clk16;
  } scp_chan_s;

  scp_chan_s   st_reg;
  scp_chan_s   st_next;
  logic [12:0] div;

  always_comb begin
    st_next = st_reg;
    div     = scp_pkg::divisor(rate_code_in);
    // A code change that leaves the count past the end wraps at once.
    if (ref_tick_in) begin
      if (st_reg.count >= div - 13'h0001) begin
        st_next.count = 13'h0000;
      end else begin
        st_next.count = st_reg.count + 13'h0001;
      end
    end
    st_next.clk16 = (st_reg.count < (div >> 1));
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign clk16_out = st_reg.clk16;

endmodule

// File: scp_port_decode_properties.sv
`timescale 1ns/1ps
// ****************************************************
// Port decode checks
// ****************************************************
module scp_port_decode_properties (
  input wire logic       sys_clk_in,          // Clock.
  input wire logic       rst_n_in,            // Reset, low.
  input wire logic [7:0] low_port_address_in, // Address.
  input wire logic       io_rd_n_in,          // Read strobe.
  input wire logic       io_wr_n_in,          // Write strobe.
  input wire logic [7:0] cpu_data_in,         // Write data.
  input wire logic [7:0] cpu_data_out,        // Read data.
  input wire logic       cpu_data_oe_out,     // Bus enable.
  input wire logic [7:0] select_n_out,        // Strobes.
  input wire logic       rts_out,             // Request to send.
  input wire logic       dtr_out,             // Terminal ready.
  input wire logic       break_n_out,         // Break control.
  input wire logic       core_reset_n_out,    // Core reset.
  input wire logic [7:0] tx_data_out,         // Transmit byte.
  input wire logic       tx_load_out,         // Transmit load.
  input wire logic [7:0] rx_data_in,          // Receive byte.
  input wire logic       rx_read_out          // Receive read.
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  sequence s_idle;
    (io_rd_n_in && io_wr_n_in) [*6];
  endsequence

  a_one_strobe: assert property ($onehot0(~select_n_out))
    else $error("more than one select strobe low");
  a_enable_read: assert property (cpu_data_oe_out == (select_n_out[7:4] != 4'hf))
    else $error("bus enable does not follow read strobes");
  a_bus_released: assert property (!cpu_data_oe_out |-> cpu_data_out == 8'h00)
    else $error("read data present while bus released");
  a_idle_no_strobe: assert property (s_idle |-> select_n_out == 8'hff)
    else $error("strobe low with processor idle");
  a_write_latency: assert property ($fell(io_wr_n_in) && low_port_address_in == 8'heb |-> ##[3:7] !select_n_out[3])
    else $error("data write strobe missing");
  a_load_pulse: assert property (tx_load_out |-> !select_n_out[3] and s_pulse(tx_load_out))
    else $error("transmit load not one cycle");
  a_tx_byte: assert property (tx_load_out |-> tx_data_out == $past(cpu_data_in, 2))
    else $error("transmit byte differs from bus");
  a_read_pulse: assert property ($fell(select_n_out[7]) |-> s_pulse(rx_read_out))
    else $error("receive read not one cycle");
  a_rx_byte: assert property ($fell(select_n_out[7]) |-> cpu_data_out == rx_data_in)
    else $error("received byte not on bus");
  a_core_reset: assert property ($fell(select_n_out[0]) |-> s_pulse(!core_reset_n_out))
    else $error("core reset pulse wrong");
  a_latch_load: assert property ($fell(select_n_out[2]) |-> {break_n_out, rts_out, dtr_out} == $past(cpu_data_in[2:0], 2))
    else $error("handshake latch not loaded");
  a_latch_hold: assert property (select_n_out[2] |-> $stable({break_n_out, rts_out, dtr_out}))
    else $error("handshake latch changed without write");
endmodule

bind scp_port_decode scp_port_decode_properties u_props (.*);

// File: scp_modem_model.sv
`timescale 1ns/1ps
// ****************************************************
// Modem side: drives status lines, watches handshake
// ****************************************************
module scp_modem_model (
  input  wire logic       sys_clk_in, // System clock.
  input  wire logic [4:0] level_in,   // CTS, DSR, DCD, RI, line.
  input  wire logic       rts_in,     // Request to send.
  input  wire logic       dtr_in,     // Terminal ready.
  output logic      [4:0] line_out,   // Modem levels.
  output logic      [1:0] seen_out    // Handshake seen.
);
  initial line_out = 5'h1f;
  always @(posedge sys_clk_in) begin
    line_out <= level_in;
    seen_out <= {rts_in, dtr_in};
  end
endmodule

// File: scp_port_decode_bench.sv
`timescale 1ns/1ps
module scp_port_decode_bench;
  logic       sys_clk_in = 1'b0, rst_n_in = 1'b0, io_rd_n_in = 1'b1, io_wr_n_in = 1'b1, xtal_ref_in = 1'b0;
  logic       rx_ready_in = 1'b0, thr_empty_in = 1'b0, overrun_in = 1'b0, framing_err_in = 1'b0;
  logic       parity_err_in = 1'b0;
  logic [7:0] low_port_address_in = 8'h00, cpu_data_in = 8'h00, config_switches_in = 8'hff, rx_data_in = 8'h00;
  logic [4:0] modem_level = 5'h1f;
  logic       cts_in, dsr_in, dcd_in, ri_in, serial_rx_in, cpu_data_oe_out, tx_clock_16x_out, rx_clock_16x_out;
  logic       rts_out, dtr_out, core_reset_n_out, even_parity_out, two_stop_out, parity_inhibit_out, break_n_out;
  logic       tx_load_out, rx_read_out;
  logic [1:0] word_len_sel_out, seen;
  logic [7:0] cpu_data_out, select_n_out, tx_data_out, q, d, r;
  logic [7:0] txq[$];
  logic [31:0] seed = 32'hf1ef;
  logic       rst_q = 1'b0;
  int         err_count = 0, check_count = 0, xticks = 0, n_rd = 0, got_rd = 0, n_rst = 0, got_rst = 0;
  int unsigned baud2[16] = '{100, 150, 220, 269, 300, 600, 1200, 2400, 3600, 4000, 4800, 7200, 9600, 14400,
                             19200, 38400};
  logic [7:0] codes[12] = '{8'h8f, 8'h9e, 8'had, 8'hbc, 8'hcb, 8'hda, 8'he9, 8'hf8, 8'h7f, 8'h34, 8'h65, 8'h22};

  scp_port_decode dut (.*);
  scp_modem_model modem (.sys_clk_in(sys_clk_in), .level_in(modem_level), .rts_in(rts_out), .dtr_in(dtr_out),
                         .line_out({cts_in, dsr_in, dcd_in, ri_in, serial_rx_in}), .seen_out(seen));

  always #20 sys_clk_in = ~sys_clk_in;
  always #98.643 xtal_ref_in = ~xtal_ref_in;
  always @(posedge xtal_ref_in) xticks++;

  // ****************************************************
  // Helpers and monitors
  // ****************************************************
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data settle before the strobe and stay through it, as the synchronisers need.
  task automatic io(input logic [7:0] a, input logic wr, input logic [7:0] dv, output logic [7:0] qv);
    logic [7:0] es;
    es = (a[7:2] == 6'h3a) ? ~(8'h01 << {~wr, a[1:0]}) : 8'hff;
    low_port_address_in <= a;
    cpu_data_in <= dv;
    cyc(6);
    io_wr_n_in <= ~wr;
    io_rd_n_in <= wr;
    cyc(8);
    qv = cpu_data_out;
    chk("select", es, select_n_out);
    chk("enable", {7'h00, ~wr & ~&es[7:4]}, {7'h00, cpu_data_oe_out});
    io_wr_n_in <= 1'b1;
    io_rd_n_in <= 1'b1;
    cpu_data_in <= ~dv;
    cyc(7);
    chk("released", 8'hff, select_n_out);
  endtask

  task automatic period(input logic rx, input logic [3:0] code);
    int t, e;
    e = scp_pkg::XTAL_REF_HZ * 2 / (scp_pkg::CLK16_FACTOR * baud2[code]);
    // Any short period left by the rate change ends at the first edge awaited here, which is not measured.
    @(posedge (rx ? rx_clock_16x_out : tx_clock_16x_out));
    t = xticks;
    @(posedge (rx ? rx_clock_16x_out : tx_clock_16x_out));
    t = xticks - t;
    check_count++;
    if (t < e - 1 || t > e + 1) begin
      err_count++;
      $display("mismatch clock period code %h expected %0d seen %0d", code, e, t);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    // The core reset output is still low one edge after release, so counting waits a cycle.
    rst_q <= rst_n_in;
    if (rst_n_in && tx_load_out === 1'b1) begin
      if (txq.size() == 0) txq.push_back(~tx_data_out);
      chk("tx data", txq.pop_front(), tx_data_out);
    end
    if (rst_n_in && rx_read_out === 1'b1) got_rd++;
    if (rst_q && core_reset_n_out === 1'b0) got_rst++;
  end

  initial begin
    cyc(95000);
    err_count++;
    $display("mismatch watchdog expected done seen timeout");
    complete_run();
  end

  initial begin
    cyc(10);
    rst_n_in <= 1'b1;
    cyc(2);
    chk("reset latch", 8'h00, {5'h00, break_n_out, rts_out, dtr_out});
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      modem_level <= r[4:0];
      config_switches_in <= rnd();
      rx_data_in <= rnd();
      {rx_ready_in, thr_empty_in, overrun_in, framing_err_in, parity_err_in} <= r[7:3];
      io(8'he8, 1'b1, rnd(), q);
      n_rst++;
      io(8'he8, 1'b0, 8'h00, q);
      chk("modem", {r[4:1], 2'b00, r[0], 1'b0}, q);
      io(8'he9, 1'b0, 8'h00, q);
      chk("switches", config_switches_in, q);
      io(8'hea, 1'b0, 8'h00, q);
      chk("status", {r[7:3], 3'b000}, q);
      io(8'heb, 1'b0, 8'h00, q);
      n_rd++;
      chk("rx data", rx_data_in, q);
      // Software keeps the switch format bits and adds its own handshake bits.
      d = {config_switches_in[7:3], 3'h0} | (rnd() & 8'h07);
      io(8'hea, 1'b1, d, q);
      chk("control", d, {even_parity_out, word_len_sel_out, two_stop_out, parity_inhibit_out, break_n_out, rts_out,
                         dtr_out});
      chk("handshake", {6'h00, d[1:0]}, {6'h00, seen});
      d = rnd();
      txq.push_back(d);
      io(8'heb, 1'b1, d, q);
      io(i[0] ? 8'he7 : 8'hec, i[1], rnd(), q);
      chk("unmapped", 8'h00, q);
    end
    $display("test ports done");
    foreach (codes[k]) begin
      io(8'he9, 1'b1, codes[k], q);
      fork
        period(1'b0, codes[k][7:4]);
        period(1'b1, codes[k][3:0]);
      join
    end
    $display("test baud done");
    chk("tx left", 8'h00, 8'(txq.size()));
    chk("rx reads", 8'(n_rd), 8'(got_rd));
    chk("core resets", 8'(n_rst), 8'(got_rst));
    complete_run();
  end
endmodule
